// ==== shared/dlyr_pkg.sv ====
// Shared constants and carriers for the delay response generator stage.
// Assumes byte-wide frames without FCS and header offsets supplied by the classifier.
package dlyr_pkg;
  localparam int DOM_W = 2;
  localparam int PORT_W = 3;
  localparam int TS_W = 80;
  localparam int IDX_W = 11;
  localparam int MEM_DEPTH = 2 ** IDX_W;
  // Timing header byte offsets, identity size, frame growth and frame limit
  localparam logic [IDX_W-1:0] OFS_TYPE = 11'h000;
  localparam logic [IDX_W-1:0] OFS_MLEN = 11'h002;
  localparam logic [IDX_W-1:0] OFS_FLAG = 11'h006;
  localparam logic [IDX_W-1:0] OFS_SPI = 11'h014;
  localparam logic [IDX_W-1:0] OFS_CTRL = 11'h020;
  localparam logic [IDX_W-1:0] OFS_LMI = 11'h021;
  localparam logic [IDX_W-1:0] OFS_TS = 11'h022;
  localparam logic [IDX_W-1:0] OFS_RPI = 11'h02c;
  localparam logic [IDX_W-1:0] PORT_ID_BYTES = 11'h00a;
  localparam logic [IDX_W-1:0] EXPAND = 11'h00a;
  localparam logic [IDX_W-1:0] MAX_FRAME = 11'h094;
  // IP and UDP header offsets
  localparam logic [IDX_W-1:0] OFS_IP4_TLEN = 11'h002;
  localparam logic [IDX_W-1:0] OFS_IP4_HCS = 11'h00a;
  localparam logic [IDX_W-1:0] OFS_IP6_PLEN = 11'h004;
  localparam logic [IDX_W-1:0] OFS_IP6_ADDR = 11'h008;
  localparam logic [IDX_W-1:0] OFS_IP6_ADDR_END = 11'h028;
  localparam logic [IDX_W-1:0] OFS_UDP_LEN = 11'h004;
  localparam logic [IDX_W-1:0] OFS_UDP_CS = 11'h006;
  // Field values written into responses, plus length and checksum constants
  localparam logic [3:0] MSG_TYPE_RESP = 4'h9;
  localparam logic [15:0] MSG_LEN_RESP = 16'h0054;
  localparam logic [7:0] CTRL_RESP = 8'h03;
  localparam logic [15:0] LEN_GROWTH = 16'h000a;
  localparam logic [15:0] UDP_PROTO = 16'h0011;
  localparam logic [15:0] UDP_LEN_REQ = 16'h002c;

  typedef enum logic [2:0] {
    ENC_ETH = 3'h1,
    ENC_IP4 = 3'h2,
    ENC_IP6 = 3'h4
  } dlyr_enc_e;

  typedef struct packed {
    logic [7:0] data;
    logic sop;
    logic eop;
  } dlyr_beat_s;

  typedef struct packed {
    logic req;
    logic ts_mode;
    logic [DOM_W-1:0] dom_sel;
    logic swap_ena;
    logic [3:0] log_int;
    dlyr_enc_e enc;
    logic [PORT_W-1:0] port;
    logic [7:0] ip_off;
    logic [7:0] udp_off;
    logic [7:0] ptp_off;
  } dlyr_action_s;

  typedef struct packed {
    logic [31:0] clock_identity_high;
    logic [31:0] clock_identity_low;
    logic [15:0] port_num;
    logic per_port_mode;
    logic [15:0] flag_val;
    logic [15:0] flag_mask;
  } dlyr_dom_cfg_s;
endpackage

// ==== core/dlyr_fifo2.sv ====
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock; output data always comes from a storage flop.
`timescale 1ns/10ps
module dlyr_fifo2 #(
  parameter int W = 10
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Sync reset, active high
  input wire logic i_wr_valid, // Write side valid
  output logic o_wr_ready, // Room for a word
  input wire logic [W-1:0] i_wr_data, // Write side data
  output logic o_rd_valid, // Word available
  input wire logic i_rd_ready, // Read side accepts
  output logic [W-1:0] o_rd_data // Oldest word
);
  logic [W-1:0] slot_ff [2];
  logic wp_ff;
  logic rp_ff;
  logic [1:0] cnt_ff;
  logic wr;
  logic rd;

  assign o_wr_ready = cnt_ff != 2'h2;
  assign o_rd_valid = cnt_ff != 2'h0;
  assign wr = i_wr_valid & o_wr_ready;
  assign rd = o_rd_valid & i_rd_ready;
  assign o_rd_data = slot_ff[rp_ff];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_ff <= 1'h0;
      rp_ff <= 1'h0;
      cnt_ff <= 2'h0;
    end else begin
      if (wr) begin
        wp_ff <= ~wp_ff;
      end
      if (rd) begin
        rp_ff <= ~rp_ff;
      end
      cnt_ff <= cnt_ff + {1'h0, wr} - {1'h0, rd};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      slot_ff[0] <= '0;
      slot_ff[1] <= '0;
    end else if (wr) begin
      slot_ff[wp_ff] <= i_wr_data;
    end
  end
endmodule

// ==== core/dlyr_csum.sv ====
// One's complement 16-bit accumulator fed one byte per cycle.
// Assumes the caller says which half of the word each byte fills.
`timescale 1ns/10ps
module dlyr_csum (
  input wire logic i_clk, // Core clock
  input wire logic i_rst, // Sync reset, active high
  input wire logic i_clr, // Load the start value
  input wire logic [15:0] i_init, // Start value
  input wire logic i_en, // Add this byte
  input wire logic i_hi, // Byte is the high half
  input wire logic [7:0] i_byte, // Byte to add
  output logic [15:0] o_sum // Running sum
);
  logic [15:0] acc_ff;
  logic [16:0] add;

  assign add = {1'h0, acc_ff} + {1'h0, (i_hi ? {i_byte, 8'h00} : {8'h00, i_byte})};
  assign o_sum = acc_ff;

  // End-around carry cannot overflow again: a carry leaves at most 16'hfffe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_ff <= 16'h0000;
    end else if (i_clr) begin
      acc_ff <= i_init;
    end else if (i_en) begin
      acc_ff <= add[15:0] + {15'h0000, add[16]};
    end
  end
endmodule

// ==== core/dlyr_gen.sv ====
// Delay response generator: stores a frame, rewrites a delay request into a response, emits it.
// Assumes the action and per-domain timestamps are valid with the first beat of each frame.
//
// Operation
// - Terminate selected delay requests and emit a generated delay response instead.
// - Action mode either writes the domain timestamp into receiveTimestamp or leaves it.
// - Generate only when the action requests it and the global enable is set.
// - messageType becomes 0x9 in both modes.
// - messageLength becomes 0x54 and the frame grows by 10 bytes.
// - Discard the frame if the grown length exceeds 148 bytes.
// - UDP length field grows by 10 bytes.
// - IPv4 total length grows by 10 bytes.
// - Masked flagField bits take the selected domain's configured flag values.
// - sourcePortIdentity is the domain clockIdentity plus a 16-bit portNumber.
// - Domain portNumber by default; per-port mode replaces its six low bits.
// - controlField becomes 0x3.
// - Multicast responses take logMessageInterval from the swap-enable and interval actions.
// - Global multicast update enable cleared keeps logMessageInterval unchanged.
// - requestingPortIdentity copies the request's original sourcePortIdentity.
// - UDP checksum recomputed for IPv6, zeroed for IPv4.
// - Address, port and TTL rewrites elsewhere combine freely with response generation.
`timescale 1ns/10ps
module dlyr_gen #(
  parameter int N_PORT = 8,
  parameter int N_DOM = 3
) (
  input wire logic i_clk, // Core clock, 50 MHz
  input wire logic i_rst, // Sync reset, active high
  input wire logic i_in_valid, // Upstream beat valid
  output logic o_in_ready, // Stage accepts a beat
  input wire dlyr_pkg::dlyr_beat_s i_in_beat, // Upstream byte with frame marks
  input wire dlyr_pkg::dlyr_action_s i_action, // Classifier action, read at sop
  input wire logic [dlyr_pkg::TS_W-1:0] i_rx_ts [N_DOM], // Ingress stamp per domain
  input wire logic i_response_generation_enable, // Global permission
  input wire logic i_multicast_interval_update_enable, // Global multicast interval update
  input wire logic [dlyr_pkg::DOM_W-1:0] i_port_time_domain_select [N_PORT], // Stamp domain per port
  input wire logic [5:0] i_port_timing_config [N_PORT], // Per-port portNumber low bits
  input wire dlyr_pkg::dlyr_dom_cfg_s i_dom_cfg [N_DOM], // Per-domain settings
  output logic o_out_valid, // Downstream beat valid
  input wire logic i_out_ready, // Downstream accepts
  output dlyr_pkg::dlyr_beat_s o_out_beat, // Downstream byte with frame marks
  output logic o_drop // Pulse: frame discarded
);
  import dlyr_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CAPT = 4'h2,
    ST_CSUM = 4'h4,
    ST_EMIT = 4'h8
  } dlyr_state_e;

  dlyr_state_e state_ff;
  logic [7:0] mem [MEM_DEPTH];
  logic [IDX_W-1:0] len_ff;
  logic [IDX_W-1:0] idx_ff;
  dlyr_action_s act_ff;
  dlyr_dom_cfg_s dcfg_ff;
  logic [5:0] ppn_ff;
  logic [TS_W-1:0] ts_ff;
  logic proc_ff;
  logic mcupd_ff;
  logic ovf_ff;
  logic drop_ff;

  logic take;
  logic first;
  logic last_in;
  logic [IDX_W-1:0] wa;
  logic [IDX_W-1:0] in_len;
  logic proc_now;
  logic [DOM_W-1:0] dsel;
  logic [DOM_W-1:0] tsel;
  logic [IDX_W-1:0] ptp;
  logic [IDX_W-1:0] ipo;
  logic [IDX_W-1:0] udo;
  logic [IDX_W-1:0] out_len;
  logic [15:0] udp_len_new;
  logic [15:0] ip_len_new;
  logic [15:0] hcs_new;
  logic [16:0] hcs_t;
  logic [16:0] init_t;
  logic [15:0] cs_sum;
  logic [15:0] cs_fin;
  logic [15:0] port16;
  logic [79:0] spi;
  logic mc;
  logic is_udp;
  logic [IDX_W-1:0] rel_ip;
  logic cs_en;
  logic ovf_cur;
  logic [7:0] rw_byte;
  logic fifo_wr_ready;
  logic emit_last;
  dlyr_beat_s emit_beat;

  function automatic logic [15:0] f_word(input logic [IDX_W-1:0] a);
    f_word = {mem[a], mem[a + 11'h001]};
  endfunction

  function automatic logic [IDX_W-1:0] f_ext(input logic [7:0] o);
    f_ext = {3'h0, o};
  endfunction

  // Rewritten byte at output position i; used for both checksum pass and emission
  function automatic logic [7:0] f_rw(input logic [IDX_W-1:0] i);
    logic [IDX_W-1:0] r;
    logic [IDX_W-1:0] ri;
    logic [IDX_W-1:0] ru;
    logic [15:0] w;
    logic [7:0] b;
    r = i - ptp;
    ri = i - ipo;
    ru = i - udo;
    w = 16'h0000;
    b = mem[i];
    if (proc_ff && i >= ptp) begin
      if (r >= OFS_RPI + PORT_ID_BYTES) begin
        b = mem[i - EXPAND];
      end
      if (r == OFS_TYPE) begin
        b = {mem[i][7:4], MSG_TYPE_RESP};
      end
      if (r == OFS_MLEN || r == OFS_MLEN + 11'h001) begin
        b = (r == OFS_MLEN) ? MSG_LEN_RESP[15:8] : MSG_LEN_RESP[7:0];
      end
      if (r == OFS_FLAG || r == OFS_FLAG + 11'h001) begin
        w = (f_word(ptp + OFS_FLAG) & ~dcfg_ff.flag_mask) | (dcfg_ff.flag_val & dcfg_ff.flag_mask);
        b = (r == OFS_FLAG) ? w[15:8] : w[7:0];
      end
      if (r >= OFS_SPI && r < OFS_SPI + PORT_ID_BYTES) begin
        b = spi[79 - 8 * (r - OFS_SPI) -: 8];
      end
      if (r == OFS_CTRL) begin
        b = CTRL_RESP;
      end
      if (r == OFS_LMI && mc && mcupd_ff && act_ff.swap_ena) begin
        b = {{4{act_ff.log_int[3]}}, act_ff.log_int};
      end
      if (act_ff.ts_mode && r >= OFS_TS && r < OFS_TS + PORT_ID_BYTES) begin
        b = ts_ff[79 - 8 * (r - OFS_TS) -: 8];
      end
      if (r >= OFS_RPI && r < OFS_RPI + PORT_ID_BYTES) begin
        b = mem[ptp + OFS_SPI + (r - OFS_RPI)];
      end
    end
    if (proc_ff && is_udp) begin
      if (ru == OFS_UDP_LEN || ru == OFS_UDP_LEN + 11'h001) begin
        b = (ru == OFS_UDP_LEN) ? udp_len_new[15:8] : udp_len_new[7:0];
      end
      // checksum cleared for IPv4, recomputed for IPv6
      if (ru == OFS_UDP_CS || ru == OFS_UDP_CS + 11'h001) begin
        w = (act_ff.enc == ENC_IP6 && state_ff == ST_EMIT) ? cs_fin : 16'h0000;
        b = (ru == OFS_UDP_CS) ? w[15:8] : w[7:0];
      end
    end
    if (proc_ff && act_ff.enc == ENC_IP4) begin
      if (ri == OFS_IP4_TLEN || ri == OFS_IP4_TLEN + 11'h001) begin
        b = (ri == OFS_IP4_TLEN) ? ip_len_new[15:8] : ip_len_new[7:0];
      end
      if (ri == OFS_IP4_HCS || ri == OFS_IP4_HCS + 11'h001) begin
        b = (ri == OFS_IP4_HCS) ? hcs_new[15:8] : hcs_new[7:0];
      end
    end
    if (proc_ff && act_ff.enc == ENC_IP6) begin
      if (ri == OFS_IP6_PLEN || ri == OFS_IP6_PLEN + 11'h001) begin
        b = (ri == OFS_IP6_PLEN) ? ip_len_new[15:8] : ip_len_new[7:0];
      end
    end
    f_rw = b;
  endfunction

  assign o_in_ready = state_ff == ST_IDLE || state_ff == ST_CAPT;
  assign take = i_in_valid && o_in_ready && (state_ff == ST_CAPT || i_in_beat.sop);
  assign first = state_ff == ST_IDLE;
  assign last_in = take && i_in_beat.eop;
  assign wa = first ? '0 : len_ff;
  // An overflow left by the previous frame must not block the next one
  assign ovf_cur = first ? 1'h0 : ovf_ff;
  assign in_len = wa + 11'h001;
  // action request gated by global enable
  assign proc_now = first ? (i_action.req && i_response_generation_enable) : proc_ff;
  assign dsel = (int'(i_action.dom_sel) < N_DOM) ? i_action.dom_sel : '0;
  assign tsel = (int'(i_port_time_domain_select[i_action.port]) < N_DOM)
              ? i_port_time_domain_select[i_action.port] : '0;

  assign ptp = f_ext(act_ff.ptp_off);
  assign ipo = f_ext(act_ff.ip_off);
  assign udo = f_ext(act_ff.udp_off);
  assign is_udp = act_ff.enc != ENC_ETH;
  assign mc = mem[0][0];
  // frame grows by the appended identity
  assign out_len = proc_ff ? len_ff + EXPAND : len_ff;
  // Kept in processes: the helpers read the frame store, which a continuous assignment would not follow
  always_comb begin
    udp_len_new = f_word(udo + OFS_UDP_LEN) + LEN_GROWTH;
    ip_len_new = f_word(ipo + ((act_ff.enc == ENC_IP4) ? OFS_IP4_TLEN : OFS_IP6_PLEN)) + LEN_GROWTH;
    // Incremental header checksum for the length change only; other IPv4 fields stay untouched here
    hcs_t = {1'h0, ~f_word(ipo + OFS_IP4_HCS)} + {1'h0, LEN_GROWTH};
    hcs_new = ~(hcs_t[15:0] + {15'h0000, hcs_t[16]});
  end
  assign port16 = dcfg_ff.per_port_mode ? {dcfg_ff.port_num[15:6], ppn_ff} : dcfg_ff.port_num;
  assign spi = {dcfg_ff.clock_identity_high, dcfg_ff.clock_identity_low, port16};
  assign init_t = {1'h0, udp_len_new} + {1'h0, UDP_PROTO};
  assign cs_fin = (~cs_sum == 16'h0000) ? 16'hffff : ~cs_sum;
  assign rel_ip = idx_ff - ipo;
  assign cs_en = state_ff == ST_CSUM
              && ((rel_ip >= OFS_IP6_ADDR && rel_ip < OFS_IP6_ADDR_END) || idx_ff >= udo);
  assign emit_last = idx_ff == out_len - 11'h001;
  // One rewritten byte feeds both the checksum pass and the output buffer
  always_comb begin
    rw_byte = f_rw(idx_ff);
    emit_beat = '{data: rw_byte, sop: idx_ff == '0, eop: emit_last};
  end

  always_ff @(posedge i_clk) begin
    if (take && !ovf_cur) begin
      mem[wa] <= i_in_beat.data;
    end
  end

  // Per-frame context is frozen at sop so mid-frame config writes cannot tear a response
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_ff <= '0;
      dcfg_ff <= '0;
      ppn_ff <= 6'h00;
      ts_ff <= '0;
      proc_ff <= 1'h0;
      mcupd_ff <= 1'h0;
    end else if (take && first) begin
      act_ff <= i_action;
      dcfg_ff <= i_dom_cfg[dsel];
      ppn_ff <= i_port_timing_config[i_action.port];
      ts_ff <= i_rx_ts[tsel];
      proc_ff <= proc_now;
      mcupd_ff <= i_multicast_interval_update_enable;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      len_ff <= '0;
      ovf_ff <= 1'h0;
    end else if (take) begin
      len_ff <= ovf_cur ? len_ff : in_len;
      ovf_ff <= ovf_cur || (in_len == '1 && !i_in_beat.eop);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      idx_ff <= '0;
      drop_ff <= 1'h0;
    end else begin
      drop_ff <= 1'h0;
      case (state_ff)
        ST_IDLE,
        ST_CAPT: begin
          if (take) begin
            state_ff <= ST_CAPT;
          end
          if (last_in) begin
            idx_ff <= '0;
            if ((proc_now && ({1'h0, in_len} + {1'h0, EXPAND} > {1'h0, MAX_FRAME})) || ovf_cur) begin
              state_ff <= ST_IDLE;
              drop_ff <= 1'h1;
            end else if (proc_now && (first ? i_action.enc : act_ff.enc) == ENC_IP6) begin
              state_ff <= ST_CSUM;
            end else begin
              state_ff <= ST_EMIT;
            end
          end
        end
        ST_CSUM: begin
          idx_ff <= idx_ff + 11'h001;
          if (emit_last) begin
            idx_ff <= '0;
            state_ff <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (fifo_wr_ready) begin
            idx_ff <= idx_ff + 11'h001;
            if (emit_last) begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  dlyr_csum u_csum (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clr(state_ff == ST_CAPT && last_in),
    .i_init(init_t[15:0] + {15'h0000, init_t[16]}),
    .i_en(cs_en),
    .i_hi(rel_ip[0] == 1'h0),
    .i_byte(rw_byte),
    .o_sum(cs_sum)
  );

  // A receiver stall fills the buffer and holds emission, so no byte is lost
  dlyr_fifo2 #(
    .W($bits(dlyr_beat_s))
  ) u_out_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_valid(state_ff == ST_EMIT),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data(emit_beat),
    .o_rd_valid(o_out_valid),
    .i_rd_ready(i_out_ready),
    .o_rd_data(o_out_beat)
  );

  assign o_drop = drop_ff;
endmodule

// ==== verif/dlyr_gen_checker.sv ====
// Stream checker for the delay response generator.
// Assumes it is bound to dlyr_gen and sees its stream ports and discard pulse only.
`timescale 1ns/10ps
module dlyr_gen_checker (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Sync reset
  input wire logic i_in_valid, // In valid
  input wire logic o_in_ready, // In ready
  input wire dlyr_pkg::dlyr_beat_s i_in_beat, // In beat
  input wire logic o_out_valid, // Out valid
  input wire logic i_out_ready, // Out ready
  input wire dlyr_pkg::dlyr_beat_s o_out_beat, // Out beat
  input wire logic o_drop // Discard pulse
);
  import dlyr_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic in_frame_ff;
  // Tracks whether the next output beat is inside a frame
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      in_frame_ff <= 1'b0;
    end else if (o_out_valid && i_out_ready) begin
      in_frame_ff <= !o_out_beat.eop;
    end
  end
  AST_RST: assert property (disable iff (1'b0) i_rst |=> !o_out_valid && !o_drop && o_in_ready)
    else $error("reset state wrong");
  AST_HOLD_VALID: assert property (o_out_valid && !i_out_ready |=> o_out_valid)
    else $error("beat withdrawn in stall");
  AST_HOLD_BEAT: assert property (o_out_valid && !i_out_ready |=> $stable(o_out_beat))
    else $error("beat changed in stall");
  AST_DROP_PULSE: assert property (o_drop |=> !o_drop)
    else $error("drop longer than a cycle");
  AST_DROP_CAUSE: assert property (o_drop |-> $past(i_in_valid && o_in_ready && i_in_beat.eop))
    else $error("drop without a frame end");
  AST_DROP_READY: assert property (o_drop |-> o_in_ready ##1 o_in_ready)
    else $error("input blocked by a drop");
  AST_EOP_GAP: assert property (o_out_valid && i_out_ready && o_out_beat.eop |=> !o_out_valid [*2])
    else $error("output right after frame end");
  AST_RDY_BACK: assert property (o_out_valid && i_out_ready && o_out_beat.eop |-> o_in_ready)
    else $error("input not reopened");
  AST_SOP_FIRST: assert property (o_out_valid && !in_frame_ff |-> o_out_beat.sop)
    else $error("frame starts without sop");
  AST_SOP_ONCE: assert property (o_out_valid && in_frame_ff |-> !o_out_beat.sop)
    else $error("sop inside a frame");
endmodule

bind dlyr_gen dlyr_gen_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_in_valid(i_in_valid),
  .o_in_ready(o_in_ready), .i_in_beat(i_in_beat), .o_out_valid(o_out_valid),
  .i_out_ready(i_out_ready), .o_out_beat(o_out_beat), .o_drop(o_drop));

// ==== verif/dlyr_sink.sv ====
// Downstream frame sink with an optional stall pattern.
// Assumes the bench reads its byte queue and frame count directly.
`timescale 1ns/10ps
module dlyr_sink (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Sync reset
  input wire logic i_valid, // Beat offered
  input wire dlyr_pkg::dlyr_beat_s i_beat, // Offered beat
  input wire logic i_stall, // Accept one beat in four
  output logic o_ready // Beat accepted
);
  import dlyr_pkg::*;
  logic [1:0] cnt_ff;
  logic [7:0] q[$];
  int nfr = 0;
  // Slow acceptance lets the two-entry buffer fill and refuse
  assign o_ready = !i_stall || (cnt_ff == 2'h0);
  always_ff @(posedge i_clk) begin
    cnt_ff <= i_rst ? 2'h0 : cnt_ff + 2'h1;
  end
  always @(posedge i_clk) begin
    if (!i_rst && i_valid && o_ready) begin
      q.push_back(i_beat.data);
      nfr += i_beat.eop ? 1 : 0;
    end
  end
endmodule

// ==== verif/dlyr_gen_tb.sv ====
// Self-checking bench for the delay response generator.
// Assumes the sink model drains the output and the checker is bound to the design.
`timescale 1ns/10ps
module dlyr_gen_tb;
  import dlyr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic rdy, ovld, ordy, drop, en, mcen, stall;
  dlyr_beat_s beat, obeat;
  dlyr_action_s act;
  dlyr_enc_e ecode;
  logic [TS_W-1:0] ts [3];
  logic [DOM_W-1:0] ptds [8];
  logic [5:0] pcfg [8];
  dlyr_dom_cfg_s dcfg [3];
  logic [7:0] fr[$];
  int err_total = 0;
  int cmp_count = 0;
  int ndrop = 0;
  int ipo, udo, pto;

  always #10 clk = ~clk;
  always @(posedge clk) ndrop += (drop === 1'b1) ? 1 : 0;

  dlyr_gen #(.N_PORT(8), .N_DOM(3)) dut (.i_clk(clk), .i_rst(rst), .i_in_valid(vld),
    .o_in_ready(rdy), .i_in_beat(beat), .i_action(act), .i_rx_ts(ts),
    .i_response_generation_enable(en), .i_multicast_interval_update_enable(mcen),
    .i_port_time_domain_select(ptds), .i_port_timing_config(pcfg), .i_dom_cfg(dcfg),
    .o_out_valid(ovld), .i_out_ready(ordy), .o_out_beat(obeat), .o_drop(drop));
  dlyr_sink snk (.i_clk(clk), .i_rst(rst), .i_valid(ovld), .i_beat(obeat), .i_stall(stall),
    .o_ready(ordy));

  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  function automatic logic [15:0] wo(int i);
    return {snk.q[i], snk.q[i+1]};
  endfunction
  function automatic logic [15:0] wi(int i);
    return {fr[i], fr[i+1]};
  endfunction
  // Pseudo header plus segment; a correct checksum folds to all ones
  function automatic logic [15:0] ucs(int n);
    logic [31:0] s;
    s = 32'(wo(udo + 4)) + 32'h0000_0011;
    for (int i = ipo + 8; i < ipo + 40; i += 2) s += 32'(wo(i));
    for (int i = udo; i < n; i += 2) s += 32'(wo(i));
    s = 32'(s[15:0]) + 32'(s[31:16]);
    s = 32'(s[15:0]) + 32'(s[31:16]);
    return s[15:0];
  endfunction
  // Frame kinds: 1 plain, 2 IPv4/UDP, 4 IPv6/UDP
  task automatic mk(int e, int n, logic mc);
    ecode = dlyr_enc_e'(3'(e));
    ipo = 14;
    udo = (e == 2) ? 34 : 54;
    pto = (e == 1) ? 14 : udo + 8;
    fr.delete();
    for (int i = 0; i < n; i++) fr.push_back(8'(i * 7 + 3));
    fr[0] = {7'h00, mc};
    fr[pto] = 8'h11;
    fr[ipo+3] = 8'(n - 14);
    fr[udo+5] = 8'h2c;
    fr[udo+4] = 8'h00;
    snk.q.delete();
  endtask
  task automatic send(logic rq, logic tm, int ds, int pt, logic [3:0] li);
    // Interval 1 doubles as the case with swap-enable cleared
    act <= '{req: rq, ts_mode: tm, dom_sel: 2'(ds), swap_ena: li != 4'h1, log_int: li, enc: ecode,
      port: 3'(pt), ip_off: 8'(ipo), udp_off: 8'(udo), ptp_off: 8'(pto)};
    for (int i = 0; i < fr.size(); i++) begin
      vld <= 1'b1;
      beat <= '{data: fr[i], sop: i == 0, eop: i == fr.size() - 1};
      do @(negedge clk); while (rdy !== 1'b1);
      @(posedge clk);
    end
    vld <= 1'b0;
  endtask
  task automatic collect(int n0);
    for (int k = 0; k < 1500 && snk.nfr == n0; k++) @(negedge clk);
    @(posedge clk);
    chk("frames", 16'(snk.nfr), 16'(n0 + 1));
  endtask
  task automatic t_pass(logic rq, logic on);
    int n0;
    n0 = snk.nfr;
    en <= on;
    mk(2, 86, 1'b1);
    send(rq, 1'b1, 0, 0, 4'h3);
    collect(n0);
    chk("size", 16'(snk.q.size()), 16'(86));
    for (int i = 0; i < 86; i++) chk("byte", {8'h00, snk.q[i]}, {8'h00, fr[i]});
  endtask
  task automatic t_resp(int e, logic tm, logic mc, logic pp, logic me, logic st, int pt,
      logic [3:0] li);
    int n0, n, p, ds;
    logic [63:0] id;
    logic [15:0] pn, fl;
    logic [79:0] rt;
    n0 = snk.nfr;
    n = (e == 2) ? 86 : 106;
    ds = (pt + 1) % 3;
    en <= 1'b1;
    mcen <= me;
    stall <= st;
    dcfg[ds].per_port_mode <= pp;
    mk(e, n, mc);
    send(1'b1, tm, ds, pt, li);
    collect(n0);
    p = pto;
    id = {dcfg[ds].clock_identity_high, dcfg[ds].clock_identity_low};
    pn = pp ? {dcfg[ds].port_num[15:6], pcfg[pt]} : dcfg[ds].port_num;
    fl = (wi(p + 6) & ~dcfg[ds].flag_mask) | (dcfg[ds].flag_val & dcfg[ds].flag_mask);
    rt = ts[ptds[pt]];
    chk("size", 16'(snk.q.size()), 16'(n + 10));
    chk("type", {8'h00, snk.q[p]}, 16'h0019);
    chk("mlen", wo(p + 2), 16'h0054);
    chk("flag", wo(p + 6), fl);
    for (int k = 0; k < 4; k++) chk("clkid", wo(p + 20 + 2 * k), id[63 - 16 * k -: 16]);
    chk("portnum", wo(p + 28), pn);
    chk("ctrl", {8'h00, snk.q[p + 32]}, 16'h0003);
    chk("lmi", {8'h00, snk.q[p + 33]}, {8'h00, (mc && me && li != 4'h1) ? {{4{li[3]}}, li} : fr[p + 33]});
    for (int k = 0; k < 5; k++) begin
      chk("rxts", wo(p + 34 + 2 * k), tm ? rt[79 - 16 * k -: 16] : wi(p + 34 + 2 * k));
      chk("reqid", wo(p + 44 + 2 * k), wi(p + 20 + 2 * k));
    end
    for (int i = 0; i < 12; i++) chk("mac", {8'h00, snk.q[i]}, {8'h00, fr[i]});
    chk("udplen", wo(udo + 4), 16'h0036);
    if (e == 2) begin
      chk("iplen", wo(ipo + 2), wi(ipo + 2) + 16'h000a);
      chk("udpcs", wo(udo + 6), 16'h0000);
    end else begin
      chk("udpcs", ucs(n + 10), 16'hffff);
    end
  endtask
  task automatic t_drop(int n);
    int n0, d0;
    n0 = snk.nfr;
    d0 = ndrop;
    stall <= 1'b0;
    mk(1, n, 1'b0);
    send(1'b1, 1'b0, 0, 3, 4'h0);
    if (n > 138) begin
      repeat (4) @(posedge clk);
      chk("drop", 16'(ndrop - d0), 16'h0001);
      chk("frames", 16'(snk.nfr - n0), 16'h0000);
    end else begin
      collect(n0);
      chk("size", 16'(snk.q.size()), 16'(n + 10));
      for (int i = 58; i < n; i++) chk("tail", {8'h00, snk.q[i + 10]}, {8'h00, fr[i]});
    end
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    beat = '0;
    act = '0;
    en = 1'b0;
    mcen = 1'b0;
    stall = 1'b0;
    for (int d = 0; d < 3; d++) begin
      ts[d] = 80'h0123_4567_89ab_cdef_0f1e + 80'(d);
      dcfg[d] = '{32'h1a2b_3c4d + 32'(d), 32'h5e6f_7081 + 32'(d), 16'h4c80 + 16'(d), 1'b0,
        16'h00a5, 16'h0f0f};
    end
    for (int i = 0; i < 8; i++) begin
      ptds[i] = 2'(i % 3);
      pcfg[i] = 6'(i + 33);
    end
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_pass(1'b0, 1'b1);
    t_pass(1'b1, 1'b0);
    t_resp(2, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 5, 4'h8);
    t_resp(2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1, 4'h7);
    t_resp(4, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 6, 4'h5);
    t_resp(4, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 2, 4'h1);
    t_drop(139);
    t_drop(138);
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
endmodule
